// File: core/pblc_ctrl.sv
// Notes on behaviour
// - mode bit 0: checker error counter stops at its maximum value.
// - mode bit 1: counter pulses at maximum, wraps to zero, keeps counting.
// - prbs field 0 disables both; field 2 enables checker only.
// - prbs field 1 sends one constant packet; checker stays off.
// - prbs field 3 enables both; generator sends packets continuously.
// - lock bit reads 1 while checker is locked, else 0.
// - sync-loss bit reads 1 after a loss, 0 otherwise; resets 0.
// - generator status bit reads 1 while generator is active.
// - power bit reads 0 in active sleep, 1 normally; resets 1.
// - at 100 Mbps in mii loopback, tx bit also drives line.
// - loopback 1 selects pcs input (10 Mbps), 2 pcs output.
// - loopback 4 selects digital (100 Mbps); software adds further writes.
// - loopback 8 selects analog, 0x10 selects reverse.
// - control register at offset 0x16, reset value 0x0100.
// - receive error counter does not increment during mii loopback.
//
// The placing of the registers and the address-and-strobe port were decided locally.
module pblc_ctrl
    import pblc_pkg::*;
(
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       reset,
    // register port
    input  wire logic [pblc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [pblc_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_write,
    input  wire logic                       reg_read,
    output logic      [pblc_pkg::DATA_W-1:0] reg_rdata,
    // phy state
    input  wire logic                       speed_100,
    input  wire logic                       mii_loopback,
    input  wire logic                       active_sleep,
    // prbs checker
    input  wire logic                       checker_locked,
    input  wire logic                       checker_sync_lost,
    input  wire logic                       checker_bit_error,
    output logic                            checker_enable,
    // packet generator engine
    input  wire logic                       gen_pkt_done,
    output logic                            gen_pkt_start,
    output logic                            gen_continuous,
    // receive error counting
    input  wire logic                       rx_error_event,
    output logic                            rx_error_count_en,
    // loopback path selects
    output logic                            lb_pcs_input,
    output logic                            lb_pcs_output,
    output logic                            lb_digital,
    output logic                            lb_analog,
    output logic                            lb_reverse,
    output logic                            tx_to_line_in_lb,
    // checker error count and interrupt
    output logic                            err_wrap_pulse,
    output logic                            irq
);
    logic [15:0]        cfg_q;          // writable fields only
    logic               sync_loss_q;
    logic [IRQ_W-1:0]   irq_status_q;
    logic [IRQ_W-1:0]   irq_mask_q;
    logic [ERR_W-1:0]   err_count;
    logic               gen_active;
    logic               lock_q;
    logic [1:0]         prbs_cfg;
    logic [4:0]         lb_sel;
    logic               gen_enable;
    logic               wr_ctrl;
    logic               rd_status;
    logic [15:0]        ctrl_view;
    logic [IRQ_W-1:0]   irq_events;

    assign wr_ctrl   = reg_write && (reg_addr == OFF_CTRL);
    assign rd_status = reg_read && (reg_addr == OFF_IRQ_STATUS);
    assign prbs_cfg  = cfg_q[BIT_PRBS_HI:BIT_PRBS_LO];
    assign lb_sel    = cfg_q[LB_MSB:0];

    // writable fields; reserved and read-only bits are masked off
    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_q <= CTRL_RESET & CTRL_WMASK;
        end else if (wr_ctrl) begin
            cfg_q <= reg_wdata & CTRL_WMASK;
        end
    end

    // prbs field decode
    always_comb begin
        gen_enable     = 1'b0;
        checker_enable = 1'b0;
        gen_continuous = 1'b0;
        case (prbs_cfg)
            PRBS_OFF:    ;
            PRBS_SINGLE: gen_enable = 1'b1;
            PRBS_CHECK:  checker_enable = 1'b1;
            PRBS_BOTH: begin
                gen_enable     = 1'b1;
                checker_enable = 1'b1;
                gen_continuous = 1'b1;
            end
            default: ;
        endcase
    end

    pblc_packet_gen u_gen (
        .mclk       (mclk),
        .reset      (reset),
        .enable     (gen_enable),
        .continuous (gen_continuous),
        .pkt_done   (gen_pkt_done),
        .pkt_start  (gen_pkt_start),
        .active     (gen_active)
    );

    pblc_err_counter #(.WIDTH(ERR_W)) u_err (
        .mclk         (mclk),
        .reset        (reset),
        .enable       (checker_enable),
        .continuous   (cfg_q[BIT_CNT_MODE]),
        .error_in     (checker_bit_error),
        .count_q      (err_count),
        .wrap_pulse_q (err_wrap_pulse)
    );

    // lock is only meaningful while the checker runs
    always_ff @(posedge mclk) begin
        if (reset) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= checker_enable && checker_locked;
        end
    end

    // sticky so a brief loss is still seen by software
    always_ff @(posedge mclk) begin
        if (reset || !checker_enable) begin
            sync_loss_q <= 1'b0;
        end else if (checker_sync_lost) begin
            sync_loss_q <= 1'b1;
        end
    end

    // loopback path one-hot decode; other codes select nothing
    assign lb_pcs_input  = (lb_sel == LB_PCS_IN) && !speed_100;
    assign lb_pcs_output = (lb_sel == LB_PCS_OUT);
    assign lb_digital    = (lb_sel == LB_DIGITAL) && speed_100;
    assign lb_analog     = (lb_sel == LB_ANALOG);
    assign lb_reverse    = (lb_sel == LB_REVERSE);

    // gated here by 100 Mbps and mii loopback, so write order does not matter
    assign tx_to_line_in_lb = speed_100 && mii_loopback && cfg_q[BIT_TX_IN_LB];

    // receive error counter gate
    assign rx_error_count_en = rx_error_event && !mii_loopback;

    // register image; reserved bits fall out as zero
    always_comb begin
        ctrl_view                 = cfg_q;
        ctrl_view[BIT_LOCK]       = lock_q;
        ctrl_view[BIT_SYNC_LOSS]  = sync_loss_q;
        ctrl_view[BIT_GEN_ACTIVE] = gen_active;
        ctrl_view[BIT_POWER]      = !active_sleep;
    end

    // interrupt events
    assign irq_events[IRQ_WRAP] = err_wrap_pulse;
    assign irq_events[IRQ_LOSS] = checker_enable && checker_sync_lost && !sync_loss_q;
    assign irq_events[IRQ_LOCK] = checker_enable && checker_locked && !lock_q;

    // read of status clears, but a same-cycle event survives
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_status_q <= '0;
        end else if (rd_status) begin
            irq_status_q <= irq_events;
        end else begin
            irq_status_q <= irq_status_q | irq_events;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_mask_q <= '0;
        end else if (reg_write && (reg_addr == OFF_IRQ_MASK)) begin
            irq_mask_q <= reg_wdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status_q & irq_mask_q);

    // read data stands in the cycle after the strobe only
    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                OFF_CTRL:       reg_rdata <= ctrl_view;
                OFF_IRQ_STATUS: reg_rdata <= {{(DATA_W-IRQ_W){1'b0}}, irq_status_q};
                OFF_IRQ_MASK:   reg_rdata <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};
                OFF_ERR_COUNT:  reg_rdata <= err_count;
                default:        reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // register port checks
    AST_RESET_VALUE: assert property (@(posedge mclk)
        $past(reset) && reg_read && reg_addr == OFF_CTRL && !active_sleep
        |=> reg_rdata == CTRL_RESET)
        else $error("control register reset value wrong");

    AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (reset)
        !reg_read |=> reg_rdata == 16'h0000)
        else $error("read data stood without a read");

    AST_POWER_READ: assert property (@(posedge mclk) disable iff (reset)
        reg_read && reg_addr == OFF_CTRL |=> reg_rdata[BIT_POWER] == !$past(active_sleep))
        else $error("power bit misreported");

    AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (reset)
        reg_read && reg_addr == OFF_CTRL |=> (reg_rdata & 16'h80A0) == 16'h0000)
        else $error("reserved bit read nonzero");

    AST_RESERVED_WRITE: assert property (@(posedge mclk) disable iff (reset)
        wr_ctrl |=> (cfg_q & ~CTRL_WMASK) == 16'h0000)
        else $error("write reached a reserved or read-only bit");

    // prbs mode checks
    AST_OFF_QUIET: assert property (@(posedge mclk) disable iff (reset)
        prbs_cfg == PRBS_OFF |-> !checker_enable && !gen_pkt_start)
        else $error("prbs off but generator or checker on");

    AST_CHECK_ONLY: assert property (@(posedge mclk) disable iff (reset)
        prbs_cfg == PRBS_CHECK |-> checker_enable && !gen_pkt_start)
        else $error("check-only mode drove the generator");

    AST_SINGLE_NO_CHECK: assert property (@(posedge mclk) disable iff (reset)
        prbs_cfg == PRBS_SINGLE |-> !checker_enable)
        else $error("checker on in single packet mode");

    // a single-mode packet ends, and the mode still holds a cycle later
    sequence s_single_pkt_end;
        prbs_cfg == PRBS_SINGLE && gen_pkt_done && gen_pkt_start;
    endsequence

    sequence s_single_kept;
        prbs_cfg == PRBS_SINGLE;
    endsequence

    AST_SINGLE_ONE_PKT: assert property (@(posedge mclk) disable iff (reset)
        s_single_pkt_end ##1 s_single_kept |-> !gen_pkt_start)
        else $error("single mode started a second packet");

    AST_CONT_RUNS: assert property (@(posedge mclk) disable iff (reset)
        prbs_cfg == PRBS_BOTH [*2] |-> gen_pkt_start && gen_active)
        else $error("continuous mode not generating");

    AST_GEN_OFF_STATUS: assert property (@(posedge mclk) disable iff (reset)
        (prbs_cfg == PRBS_OFF || prbs_cfg == PRBS_CHECK) [*2] |-> !gen_active)
        else $error("generator status on while generation disabled");

    // checker status checks
    AST_LOCK_OFF: assert property (@(posedge mclk) disable iff (reset)
        !checker_enable |=> !lock_q)
        else $error("lock reported with the checker off");

    AST_STATUS_AFTER_RESET: assert property (@(posedge mclk) disable iff (reset)
        $past(reset) |-> !sync_loss_q && !lock_q && !gen_active)
        else $error("status bits not clear after reset");

    AST_SYNC_STICKY: assert property (@(posedge mclk) disable iff (reset)
        sync_loss_q && checker_enable |=> sync_loss_q || !checker_enable)
        else $error("sync loss cleared while checker ran");

    AST_SYNC_SET: assert property (@(posedge mclk) disable iff (reset)
        checker_enable && checker_sync_lost |=> sync_loss_q || !checker_enable)
        else $error("sync loss not recorded");

    // loopback and line checks
    AST_TX_LINE: assert property (@(posedge mclk) disable iff (reset)
        tx_to_line_in_lb |-> speed_100 && mii_loopback)
        else $error("line transmit outside 100 Mbps mii loopback");

    AST_RXERR_GATE: assert property (@(posedge mclk) disable iff (reset)
        mii_loopback |-> !rx_error_count_en)
        else $error("receive errors counted in mii loopback");

    AST_PCS_IN_10M: assert property (@(posedge mclk) disable iff (reset)
        lb_pcs_input |-> !speed_100 && lb_sel == LB_PCS_IN)
        else $error("pcs input loopback outside 10 Mbps");

    AST_PCS_OUT_ONLY: assert property (@(posedge mclk) disable iff (reset)
        lb_sel == LB_PCS_OUT |-> lb_pcs_output && !lb_pcs_input && !lb_digital)
        else $error("pcs output loopback decode wrong");

    AST_DIGITAL_100M: assert property (@(posedge mclk) disable iff (reset)
        lb_digital |-> speed_100 && lb_sel == LB_DIGITAL)
        else $error("digital loopback outside 100 Mbps");

    AST_LB_DECODE: assert property (@(posedge mclk) disable iff (reset)
        lb_sel == LB_REVERSE |-> lb_reverse && !lb_analog && !lb_digital)
        else $error("reverse loopback decode wrong");
endmodule : pblc_ctrl

// File: core/pblc_err_counter.sv
// checker error counter: saturating or wrapping with a pulse
module pblc_err_counter
    import pblc_pkg::*;
#(
    parameter int WIDTH = pblc_pkg::ERR_W
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // control
    input  wire logic             enable,
    input  wire logic             continuous,
    input  wire logic             error_in,
    // result
    output logic [WIDTH-1:0]      count_q,
    output logic                  wrap_pulse_q
);
    logic at_max;

    assign at_max = &count_q;

    // counter holds at zero while the checker is disabled
    always_ff @(posedge mclk) begin
        if (reset || !enable) begin
            count_q <= '0;
        end else if (error_in) begin
            if (!at_max) begin
                count_q <= count_q + 1'b1;
            end else if (continuous) begin
                count_q <= '0;
            end                                       // else hold
        end
    end

    // one pulse as the counter wraps from its top value
    always_ff @(posedge mclk) begin
        if (reset) begin
            wrap_pulse_q <= 1'b0;
        end else begin
            wrap_pulse_q <= enable && error_in && at_max && continuous;
        end
    end

    // counter checks
    AST_SATURATE_HOLDS: assert property (@(posedge mclk) disable iff (reset)
        (enable && !continuous && at_max) |=> (&count_q || !$past(enable)))
        else $error("error counter left its top value in single mode");

    AST_WRAP_TO_ZERO: assert property (@(posedge mclk) disable iff (reset)
        (enable && continuous && at_max && error_in) |=> (count_q == '0 && wrap_pulse_q))
        else $error("error counter did not wrap with a pulse");
endmodule : pblc_err_counter

// File: core/pblc_packet_gen.sv
// packet generator sequencer: single or continuous packets
module pblc_packet_gen
    import pblc_pkg::*;
(
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // control
    input  wire logic             enable,
    input  wire logic             continuous,
    // packet engine handshake
    input  wire logic             pkt_done,
    output logic                  pkt_start,
    // status
    output logic                  active
);
    pblc_gen_state_t state_q;
    pblc_gen_state_t state_d;

    // single mode ends after one packet until disabled or made continuous
    always_comb begin
        state_d = state_q;
        case (state_q)
            PBLC_GEN_IDLE: if (enable) state_d = PBLC_GEN_RUN;
            PBLC_GEN_RUN: begin
                if (!enable) begin
                    state_d = PBLC_GEN_IDLE;
                end else if (pkt_done && !continuous) begin
                    state_d = PBLC_GEN_DONE;
                end
            end
            PBLC_GEN_DONE: begin
                if (!enable) begin
                    state_d = PBLC_GEN_IDLE;
                end else if (continuous) begin
                    state_d = PBLC_GEN_RUN;
                end
            end
            default: state_d = PBLC_GEN_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= PBLC_GEN_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // engine runs while in RUN; continuous keeps it there
    assign pkt_start = (state_q == PBLC_GEN_RUN) && enable;
    assign active    = (state_q == PBLC_GEN_RUN);
endmodule : pblc_packet_gen

// File: core/pblc_pkg.sv
package pblc_pkg;
    // register bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    // self-test and loopback control register
    localparam logic [4:0]  OFF_CTRL        = 5'h16;
    localparam logic [15:0] CTRL_RESET      = 16'h0100;
    // interrupt status and mask (chosen offsets)
    localparam logic [4:0]  OFF_IRQ_STATUS  = 5'h18;
    localparam logic [4:0]  OFF_IRQ_MASK    = 5'h19;
    // checker error count readback (chosen offset)
    localparam logic [4:0]  OFF_ERR_COUNT   = 5'h1A;
    // field positions
    localparam int BIT_CNT_MODE   = 14;
    localparam int BIT_PRBS_HI    = 13;
    localparam int BIT_PRBS_LO    = 12;
    localparam int BIT_LOCK       = 11;
    localparam int BIT_SYNC_LOSS  = 10;
    localparam int BIT_GEN_ACTIVE = 9;
    localparam int BIT_POWER      = 8;
    localparam int BIT_TX_IN_LB   = 6;
    localparam int LB_MSB         = 4;
    // writable bits of the control register
    localparam logic [15:0] CTRL_WMASK    = 16'h705F;
    // prbs configuration codes
    localparam logic [1:0] PRBS_OFF      = 2'h0;
    localparam logic [1:0] PRBS_SINGLE   = 2'h1;
    localparam logic [1:0] PRBS_CHECK    = 2'h2;
    localparam logic [1:0] PRBS_BOTH     = 2'h3;
    // loopback select codes
    localparam logic [4:0] LB_NONE       = 5'h00;
    localparam logic [4:0] LB_PCS_IN     = 5'h01;
    localparam logic [4:0] LB_PCS_OUT    = 5'h02;
    localparam logic [4:0] LB_DIGITAL    = 5'h04;
    localparam logic [4:0] LB_ANALOG     = 5'h08;
    localparam logic [4:0] LB_REVERSE    = 5'h10;
    // interrupt status bit positions
    localparam int IRQ_WRAP  = 0;
    localparam int IRQ_LOSS  = 1;
    localparam int IRQ_LOCK  = 2;
    localparam int IRQ_W     = 3;
    // checker error counter width
    localparam int ERR_W = 16;
    // generator states
    typedef enum logic [1:0] {
        PBLC_GEN_IDLE,
        PBLC_GEN_RUN,
        PBLC_GEN_DONE
    } pblc_gen_state_t;
endpackage : pblc_pkg

// File: verification/pblc_ctrl_tb_top.sv
module pblc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pblc_pkg::*;
    logic mclk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, rv;
    logic speed_100 = 1'b0, mii_loopback = 1'b0, active_sleep = 1'b0, rx_error_event = 1'b0;
    logic slow = 1'b0, lose_sync = 1'b0, make_err = 1'b0;
    logic checker_locked, checker_sync_lost, checker_bit_error, checker_enable;
    logic gen_pkt_done, gen_pkt_start, gen_continuous, rx_error_count_en, tx_to_line_in_lb;
    logic lb_pcs_input, lb_pcs_output, lb_digital, lb_analog, lb_reverse, err_wrap_pulse, irq;
    int num_errors = 0, n_compared = 0, wraps = 0;
    // 25 MHz
    always #20 mclk = ~mclk;
    // wrap pulses last one cycle, so count them at every edge
    always @(posedge mclk) if (err_wrap_pulse === 1'b1) wraps++;
    pblc_ctrl i_pblc_ctrl (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .speed_100(speed_100), .mii_loopback(mii_loopback),
        .active_sleep(active_sleep), .checker_locked(checker_locked),
        .checker_sync_lost(checker_sync_lost), .checker_bit_error(checker_bit_error),
        .checker_enable(checker_enable), .gen_pkt_done(gen_pkt_done),
        .gen_pkt_start(gen_pkt_start), .gen_continuous(gen_continuous),
        .rx_error_event(rx_error_event), .rx_error_count_en(rx_error_count_en),
        .lb_pcs_input(lb_pcs_input), .lb_pcs_output(lb_pcs_output), .lb_digital(lb_digital),
        .lb_analog(lb_analog), .lb_reverse(lb_reverse), .tx_to_line_in_lb(tx_to_line_in_lb),
        .err_wrap_pulse(err_wrap_pulse), .irq(irq));
    pblc_far_model i_pblc_far_model (.mclk(mclk), .reset(reset), .slow(slow),
        .lose_sync(lose_sync), .make_err(make_err), .gen_pkt_start(gen_pkt_start),
        .checker_enable(checker_enable), .gen_pkt_done(gen_pkt_done),
        .checker_locked(checker_locked), .checker_sync_lost(checker_sync_lost),
        .checker_bit_error(checker_bit_error));
    // register bus: one-cycle strobes, an idle cycle between accesses
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
        #1;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // first read strobe lands on the first edge after release
    task automatic t_reset();
        reg_addr <= OFF_CTRL;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 chk("ctrl reset", CTRL_RESET, reg_rdata);
        rd(OFF_IRQ_MASK);
        chk("mask reset", 16'h0000, rv);
        wr(OFF_CTRL, 16'h8FA0);
        rd(OFF_CTRL);
        chk("reserved bits", 16'h0100, rv);
        rd(5'h05);
        chk("unmapped", 16'h0000, rv);
        @(posedge mclk) active_sleep <= 1'b1;
        rd(OFF_CTRL);
        chk("sleep power", 16'h0000, rv);
        @(posedge mclk) active_sleep <= 1'b0;
    endtask : t_reset
    task automatic t_prbs();
        for (int c = 0; c < 4; c++) begin
            wr(OFF_CTRL, 16'(c) << 12);
            chk("checker on", 16'(c >> 1), 16'(checker_enable));
            chk("continuous", 16'(c == 3), 16'(gen_continuous));
        end
        wr(OFF_CTRL, 16'h0000);
        @(posedge mclk) slow <= 1'b1;
        wr(OFF_CTRL, 16'h1000);
        rd(OFF_CTRL);
        chk("gen running", 16'h1300, rv);
        for (int n = 0; n < 20 && gen_pkt_done !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        chk("packet done", 16'h1, 16'(gen_pkt_done));
        repeat (4) @(posedge mclk);
        #1 chk("single stop", 16'h0, 16'(gen_pkt_start));
        rd(OFF_CTRL);
        chk("gen idle", 16'h1100, rv);
    endtask : t_prbs
    task automatic t_cont();
        int dn;
        dn = 0;
        @(posedge mclk) slow <= 1'b0;
        wr(OFF_CTRL, 16'h3000);
        repeat (30) begin
            @(posedge mclk);
            #1 dn += int'(gen_pkt_done === 1'b1);
        end
        chk("many packets", 16'h1, 16'(dn > 2 && gen_pkt_start === 1'b1));
        rd(OFF_CTRL);
        chk("cont status", 16'h3B00, rv);
    endtask : t_cont
    task automatic t_sync();
        wr(OFF_CTRL, 16'h2000);
        repeat (8) @(posedge mclk);
        rd(OFF_CTRL);
        chk("locked", 16'h2900, rv);
        chk("masked irq", 16'h0, 16'(irq));
        wr(OFF_IRQ_MASK, 16'h0002);
        @(posedge mclk) lose_sync <= 1'b1;
        repeat (2) @(posedge mclk);
        lose_sync <= 1'b0;
        repeat (8) @(posedge mclk);
        #1 chk("loss irq", 16'h1, 16'(irq));
        rd(OFF_CTRL);
        chk("loss sticky", 16'h2D00, rv);
        rd(OFF_IRQ_STATUS);
        chk("status", 16'h0006, rv);
        rd(OFF_IRQ_STATUS);
        chk("status cleared", 16'h0000, rv);
        chk("irq cleared", 16'h0, 16'(irq));
        wr(OFF_CTRL, 16'h0000);
        rd(OFF_CTRL);
        chk("loss cleared", 16'h0100, rv);
    endtask : t_sync
    task automatic t_errcnt();
        wr(OFF_CTRL, 16'h2000);
        @(posedge mclk) make_err <= 1'b1;
        repeat (65540) @(posedge mclk);
        make_err <= 1'b0;
        rd(OFF_ERR_COUNT);
        chk("saturated", 16'hFFFF, rv);
        chk("no wrap", 16'h0, 16'(wraps));
        wr(OFF_IRQ_MASK, 16'h0001);
        wr(OFF_CTRL, 16'h6000);
        @(posedge mclk) make_err <= 1'b1;
        @(posedge mclk) make_err <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 chk("wrap pulse", 16'h1, 16'(wraps));
        chk("wrap irq", 16'h1, 16'(irq));
        rd(OFF_ERR_COUNT);
        chk("wrapped", 16'h0000, rv);
        rd(OFF_IRQ_STATUS);
        chk("wrap status", 16'h1, 16'(rv[IRQ_WRAP]));
    endtask : t_errcnt
    task automatic t_loop();
        logic [4:0] sel, exp;
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 5; i++) begin
                sel = 5'(1 << i);
                exp = sel & ((s == 1) ? 5'h1E : 5'h1B);
                @(posedge mclk) speed_100 <= 1'(s);
                wr(OFF_CTRL, {11'h000, sel});
                chk("loopback", 16'(exp), 16'({lb_reverse, lb_analog, lb_digital,
                    lb_pcs_output, lb_pcs_input}));
            end
        end
        @(posedge mclk) mii_loopback <= 1'b1;
        wr(OFF_CTRL, 16'h0040);
        chk("tx to line", 16'h1, 16'(tx_to_line_in_lb));
        @(posedge mclk) speed_100 <= 1'b0;
        #1 chk("tx at 10M", 16'h0, 16'(tx_to_line_in_lb));
        @(posedge mclk) rx_error_event <= 1'b1;
        #1 chk("rx err in lb", 16'h0, 16'(rx_error_count_en));
        @(posedge mclk) mii_loopback <= 1'b0;
        #1 chk("rx err count", 16'h1, 16'(rx_error_count_en));
        @(posedge mclk) rx_error_event <= 1'b0;
    endtask : t_loop
    task automatic finish_test();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    // main sequence; the error burst dominates the run time
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_prbs();
        t_cont();
        t_sync();
        t_errcnt();
        t_loop();
        finish_test();
    end
    // watchdog well past the expected 66k cycles
    initial begin
        #3_600_000;
        num_errors++;
        finish_test();
    end
endmodule : pblc_ctrl_tb_top

// File: verification/pblc_far_model.sv
// packet engine, prbs checker and error source beside the control block
module pblc_far_model (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // bench commands
    input  wire logic slow,
    input  wire logic lose_sync,
    input  wire logic make_err,
    // block side
    input  wire logic gen_pkt_start,
    input  wire logic checker_enable,
    output logic      gen_pkt_done,
    output logic      checker_locked,
    output logic      checker_sync_lost,
    output logic      checker_bit_error
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] pkt_cnt_q;
    logic [1:0] lock_cnt_q;
    // packets are short or long; done is a one-cycle pulse
    always_ff @(posedge mclk) begin
        if (reset || !gen_pkt_start || gen_pkt_done) begin
            pkt_cnt_q    <= 4'h0;
            gen_pkt_done <= 1'b0;
        end else if (pkt_cnt_q == (slow ? 4'h8 : 4'h1)) begin
            gen_pkt_done <= 1'b1;
        end else begin
            pkt_cnt_q <= pkt_cnt_q + 4'h1;
        end
    end
    // lock takes a few cycles, so a lagging lock bit is exposed
    always_ff @(posedge mclk) begin
        if (reset || !checker_enable || lose_sync)
            lock_cnt_q <= 2'h0;
        else if (lock_cnt_q != 2'h3)
            lock_cnt_q <= lock_cnt_q + 2'h1;
    end
    // a disabled checker reports no loss or error; lock drops one cycle after disable
    assign checker_locked    = (lock_cnt_q == 2'h3);
    assign checker_sync_lost = lose_sync & checker_enable;
    assign checker_bit_error = make_err & checker_enable;
endmodule : pblc_far_model
